// [cpu_program_flow_core.sv]
// Program counter, return stack, interrupt context and indirect pointers of an
// 8-bit CPU core, with an Avalon-MM register slave and a level interrupt.
// Assumes program memory and data memory both read combinationally. A program-memory
// read through a pointer spends one extra cycle with the pointer on pm_addr, so a
// slower program array must answer within that cycle.
//
// Summary of operation
// (R1) A dedicated 16-entry, 15-bit return stack is kept apart from data memory.
// (R2) A push onto a full stack or a pop from an empty one sets the overflow or underflow flag.
// (R3) With stack-error reset enabled, such an error also issues a software reset.
// (R4) Interrupt entry saves core registers to shadows and the interrupt return restores them.
// (R5) Two 16-bit indirect pointers reach all file registers and program memory.
// (R6) An indirect access into program memory takes one extra cycle to fetch the word.
// (R7) A linear pointer window maps contiguous space onto the 80-byte banks of RAM.
// (R8) The program counter is 15 bits wide over a 32K x 14 address space.
// (R9) Only 4096 words exist, so program addresses wrap within them.
// (R10) Reset starts at 0000h and interrupts vector to 0004h.
// (R11) The decoder accepts exactly 49 instruction classes and flags any other.
// (R12) Pointer bit 15 selects program memory, reads give the low byte, writes are dropped.
// (R13) Calls and interrupt entry push the return address, returns pop it into the counter.
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module cpu_program_flow_core #(
    parameter int NUM_INSTR = flow_pkg::NUM_INSTR
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM register slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // Flow command from the instruction sequencer
    input wire logic cmd_valid,
    input wire flow_pkg::cmd_t cmd,
    output logic cmd_ready,
    // Interrupt context
    input wire flow_pkg::ctx_t ctx_in,
    output flow_pkg::ctx_t ctx_restore,
    output logic ctx_restore_valid,
    // Program memory
    output logic [flow_pkg::PM_AW-1:0] pm_addr,
    input wire logic [flow_pkg::PM_DW-1:0] pm_rdata,
    // Data memory
    output logic [flow_pkg::DM_AW-1:0] dm_addr,
    output logic dm_we,
    output logic [7:0] dm_wdata,
    input wire logic [7:0] dm_rdata,
    // Results
    output logic [7:0] ind_rdata,
    output logic ind_rvalid,
    output logic [flow_pkg::PC_W-1:0] pc,
    output logic soft_reset
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [flow_pkg::PC_W-1:0] pc;
        logic [flow_pkg::STACK_DEPTH-1:0][flow_pkg::PC_W-1:0] stk;
        logic [flow_pkg::SP_W-1:0] sp;
        logic [1:0][flow_pkg::PTR_W-1:0] ptr;
        logic [1:0][flow_pkg::PTR_W-1:0] shadow_ptr;
        flow_pkg::ctx_t shadow;
        logic stk_rst_en;
        logic [1:0] power_control_register;
        logic [flow_pkg::EVT_W-1:0] evt;
        logic [flow_pkg::EVT_W-1:0] evt_en;
        flow_pkg::mode_t mode;
        // Pointer of a pending program fetch; the command bus may move on meanwhile.
        logic pm_sel;
        logic [7:0] ind_rdata;
        logic ind_rvalid;
        logic restore_valid;
        logic soft_reset;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [flow_pkg::EVT_W-1:0] evt_set;
    logic [flow_pkg::EVT_W-1:0] evt_clr;
    logic stack_err;
    logic bus_req;
    logic [3:0] top_idx;
    logic [flow_pkg::PTR_W-1:0] sel_ptr;
    logic [flow_pkg::PTR_W-1:0] fetch_ptr;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic insn_legal(input logic [flow_pkg::CLS_W-1:0] cls);
        insn_legal = 32'(cls) < NUM_INSTR; // R11
    endfunction : insn_legal

    // Linear addresses fold onto the GPR part of each 128-byte bank.
    function automatic logic [flow_pkg::DM_AW-1:0] dm_map(input logic [flow_pkg::PTR_W-1:0] p);
        logic [flow_pkg::PTR_W-1:0] off;
        logic [flow_pkg::PTR_W-1:0] bank;
        logic [flow_pkg::PTR_W-1:0] ofs;
        off = p - flow_pkg::LIN_BASE;
        bank = off / flow_pkg::LIN_BANK_BYTES;
        ofs = off % flow_pkg::LIN_BANK_BYTES;
        if (p >= flow_pkg::LIN_BASE && off < flow_pkg::LIN_SPAN) begin // R7
            dm_map = {bank[4:0], 7'(ofs[6:0] + flow_pkg::GPR_OFFSET)};
        end else begin
            dm_map = p[flow_pkg::DM_AW-1:0];
        end
    endfunction : dm_map

    function automatic logic is_pm(input logic [flow_pkg::PTR_W-1:0] p);
        is_pm = p[flow_pkg::PM_SEL_BIT]; // R12
    endfunction : is_pm

    // ------------------------------------------------------------
    // Ports driven from state and from the bus and command inputs
    // ------------------------------------------------------------
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~s_q.ack;
    assign avs_readdata = s_q.rdata;
    assign irq = |(s_q.evt & s_q.evt_en);
    assign cmd_ready = s_q.mode == flow_pkg::MODE_RUN;
    assign top_idx = 4'(s_q.sp - 1'b1);
    assign sel_ptr = s_q.ptr[cmd.sel];
    assign fetch_ptr = s_q.ptr[s_q.pm_sel];
    // The fetch address simply drops the upper counter bits.
    assign pm_addr = (s_q.mode == flow_pkg::MODE_PM_WAIT) ?
        fetch_ptr[flow_pkg::PM_AW-1:0] : s_q.pc[flow_pkg::PM_AW-1:0]; // R9
    assign dm_addr = dm_map(sel_ptr); // R5
    assign dm_we = cmd_valid & cmd_ready & (cmd.op == flow_pkg::OP_IND_WRITE)
        & insn_legal(cmd.insn_class) & ~is_pm(sel_ptr); // R12
    assign dm_wdata = cmd.data[7:0];
    assign ind_rdata = s_q.ind_rdata;
    assign ind_rvalid = s_q.ind_rvalid;
    assign ctx_restore = s_q.shadow;
    assign ctx_restore_valid = s_q.restore_valid;
    assign pc = s_q.pc;
    assign soft_reset = s_q.soft_reset;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        evt_set = '0;
        evt_clr = '0;
        stack_err = 1'b0;
        s_d.ind_rvalid = 1'b0;
        s_d.restore_valid = 1'b0;
        s_d.soft_reset = 1'b0;
        s_d.ack = bus_req & ~s_q.ack;

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        // A write lands at the edge where waitrequest is low.
        if (s_q.ack && avs_write) begin
            case (avs_address)
                flow_pkg::REG_CTRL: begin
                    s_d.stk_rst_en = avs_writedata[flow_pkg::CTRL_STK_RST_BIT];
                end
                flow_pkg::REG_POWER_CONTROL: begin
                    s_d.power_control_register = s_q.power_control_register & avs_writedata[1:0];
                end
                flow_pkg::REG_EVT_CLEAR: begin
                    evt_clr = avs_writedata[flow_pkg::EVT_W-1:0];
                end
                flow_pkg::REG_EVT_ENABLE: begin
                    s_d.evt_en = avs_writedata[flow_pkg::EVT_W-1:0];
                end
                flow_pkg::REG_POINTER0: begin
                    s_d.ptr[0] = avs_writedata[flow_pkg::PTR_W-1:0];
                end
                flow_pkg::REG_POINTER1: begin
                    s_d.ptr[1] = avs_writedata[flow_pkg::PTR_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        // Read data is captured while waitrequest is high and shown next cycle.
        if (bus_req && !s_q.ack) begin
            case (avs_address)
                flow_pkg::REG_CTRL: s_d.rdata = 32'(s_q.stk_rst_en);
                flow_pkg::REG_POWER_CONTROL: s_d.rdata = 32'(s_q.power_control_register);
                flow_pkg::REG_EVT_STATUS: s_d.rdata = 32'(s_q.evt);
                flow_pkg::REG_EVT_ENABLE: s_d.rdata = 32'(s_q.evt_en);
                flow_pkg::REG_POINTER0: s_d.rdata = 32'(s_q.ptr[0]);
                flow_pkg::REG_POINTER1: s_d.rdata = 32'(s_q.ptr[1]);
                flow_pkg::REG_FLOW: begin
                    s_d.rdata = 32'(s_q.pc) | (32'(s_q.sp) << flow_pkg::FLOW_SP_LSB);
                end
                default: s_d.rdata = '0;
            endcase
        end

        // ------------------------------------------------------------
        // Command flow
        // ------------------------------------------------------------
        // Nothing is taken while a program fetch is pending, so one bubble follows it.
        case (s_q.mode)
            flow_pkg::MODE_PM_WAIT: begin
                // Second cycle of a program-memory read: the word is now valid.
                s_d.ind_rdata = pm_rdata[7:0]; // R6
                s_d.ind_rvalid = 1'b1;
                s_d.mode = flow_pkg::MODE_RUN;
            end
            default: begin
                if (cmd_valid && !insn_legal(cmd.insn_class)) begin
                    evt_set[flow_pkg::EVT_ILLEGAL_BIT] = 1'b1; // R11
                end else if (cmd_valid) begin
                    s_d.pc = s_q.pc + 1'b1; // R8
                    case (cmd.op)
                        flow_pkg::OP_GOTO: s_d.pc = cmd.target;
                        flow_pkg::OP_CALL, flow_pkg::OP_INT_ENTRY: begin
                            if (s_q.sp == flow_pkg::SP_FULL) begin
                                s_d.power_control_register[flow_pkg::OVF_BIT] = 1'b1; // R2
                                evt_set[flow_pkg::OVF_BIT] = 1'b1;
                                stack_err = 1'b1;
                            end else begin
                                s_d.stk[s_q.sp[3:0]] = (cmd.op == flow_pkg::OP_CALL) ?
                                    s_q.pc + 1'b1 : s_q.pc; // R1 R13
                                s_d.sp = s_q.sp + 1'b1;
                            end
                            if (cmd.op == flow_pkg::OP_CALL) begin
                                s_d.pc = cmd.target;
                            end else begin
                                s_d.pc = flow_pkg::INT_VECTOR; // R10
                                s_d.shadow = ctx_in; // R4
                                s_d.shadow_ptr = s_q.ptr;
                                evt_set[flow_pkg::EVT_INT_BIT] = 1'b1;
                            end
                        end
                        flow_pkg::OP_RETURN, flow_pkg::OP_RETFIE: begin
                            if (s_q.sp == '0) begin
                                s_d.power_control_register[flow_pkg::UNF_BIT] = 1'b1; // R2
                                evt_set[flow_pkg::UNF_BIT] = 1'b1;
                                stack_err = 1'b1;
                                s_d.pc = flow_pkg::RESET_VECTOR;
                            end else begin
                                s_d.pc = s_q.stk[top_idx]; // R13
                                s_d.sp = s_q.sp - 1'b1;
                            end
                            if (cmd.op == flow_pkg::OP_RETFIE) begin
                                s_d.ptr = s_q.shadow_ptr; // R4
                                s_d.restore_valid = 1'b1;
                            end
                        end
                        flow_pkg::OP_PTR_LOAD: s_d.ptr[cmd.sel] = cmd.data; // R5
                        flow_pkg::OP_IND_READ: begin
                            if (is_pm(sel_ptr)) begin
                                s_d.mode = flow_pkg::MODE_PM_WAIT; // R6
                                s_d.pm_sel = cmd.sel;
                            end else begin
                                s_d.ind_rdata = dm_rdata;
                                s_d.ind_rvalid = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        endcase

        // ------------------------------------------------------------
        // Stack fault reset
        // ------------------------------------------------------------
        // A stack fault with the reset armed restarts the flow from the vector.
        if (stack_err && s_q.stk_rst_en) begin
            s_d.soft_reset = 1'b1; // R3
            s_d.pc = flow_pkg::RESET_VECTOR;
            s_d.sp = '0;
        end

        // Hardware set wins over a software clear in the same cycle.
        s_d.evt = (s_q.evt & ~evt_clr) | evt_set;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0; // R10
        end else begin
            s_q <= s_d;
        end
    end

endmodule : cpu_program_flow_core

// [cpu_program_flow_core_assertions.sv]
// Concurrent checks on the ports of the program-flow core.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/10ps
module flow_core_checker #(
    parameter int NUM_INSTR = flow_pkg::NUM_INSTR
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic cmd_valid,
    input wire flow_pkg::cmd_t cmd,
    input wire logic cmd_ready,
    input wire logic [flow_pkg::PC_W-1:0] pc,
    input wire logic [flow_pkg::PM_AW-1:0] pm_addr,
    input wire logic ind_rvalid,
    input wire logic ctx_restore_valid,
    input wire logic soft_reset,
    input wire logic dm_we,
    input wire logic [7:0] dm_wdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence took(flow_pkg::op_t o);
        cmd_valid && cmd_ready && cmd.op == o;
    endsequence
    // The program fetch stalls exactly one cycle, then the byte is delivered.
    sequence pm_stall;
        !cmd_ready ##1 (cmd_ready && ind_rvalid);
    endsequence
    reset_start_a: assert property ($fell(reset) |-> pc == flow_pkg::RESET_VECTOR)
        else $error("pc not at reset vector");
    int_vector_a: assert property (took(flow_pkg::OP_INT_ENTRY) |=>
        pc == flow_pkg::INT_VECTOR || soft_reset) else $error("interrupt vector wrong");
    call_jump_a: assert property (took(flow_pkg::OP_CALL) |=>
        pc == $past(cmd.target) || soft_reset) else $error("call target not taken");
    step_wrap_a: assert property ((took(flow_pkg::OP_STEP) ##0 cmd.insn_class < NUM_INSTR)
        |=> pc == $past(pc) + 15'h0001) else $error("pc did not advance");
    pm_addr_a: assert property (cmd_ready |-> pm_addr == pc[11:0])
        else $error("program address not wrapped pc");
    pm_fetch_a: assert property ($fell(cmd_ready) |-> pm_stall)
        else $error("program fetch stall wrong");
    soft_reset_a: assert property (soft_reset |-> pc == flow_pkg::RESET_VECTOR ##1 !soft_reset)
        else $error("software reset pulse wrong");
    ctx_return_a: assert property (took(flow_pkg::OP_RETFIE) |=>
        ctx_restore_valid ##1 !ctx_restore_valid) else $error("context restore pulse wrong");
    data_write_a: assert property (dm_we |-> cmd_valid && cmd.op == flow_pkg::OP_IND_WRITE
        && dm_wdata == cmd.data[7:0]) else $error("stray data write");
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus wait longer than one cycle");
endmodule : flow_core_checker

bind cpu_program_flow_core flow_core_checker #(.NUM_INSTR(NUM_INSTR)) i_flow_core_checker (
    .clk(clk), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .pc(pc), .pm_addr(pm_addr), .ind_rvalid(ind_rvalid),
    .ctx_restore_valid(ctx_restore_valid), .soft_reset(soft_reset), .dm_we(dm_we),
    .dm_wdata(dm_wdata)
);

// [flow_mem_model.sv]
// Program and data memory arrays that sit beside the program-flow core.
// Assumes one clock; each program word is a fixed pattern of its address.
`timescale 1ns/10ps
module flow_mem_model (
    // Clock
    input wire logic clk,
    // Program memory
    input wire logic [11:0] pm_addr,
    output logic [13:0] pm_rdata,
    // Data memory
    input wire logic [11:0] dm_addr,
    input wire logic dm_we,
    input wire logic [7:0] dm_wdata,
    output logic [7:0] dm_rdata
);
    logic [7:0] ram_q [4096];
    // The program word is read combinationally; the core spends its extra fetch cycle on it.
    assign pm_rdata = {2'b01, pm_addr ^ 12'hA5C};
    always_ff @(posedge clk) begin
        if (dm_we) begin
            ram_q[dm_addr] <= dm_wdata;
        end
    end
    assign dm_rdata = ram_q[dm_addr];
endmodule : flow_mem_model

// [flow_pkg.sv]
// Shared constants and types for the program-flow core.
// Assumes a single 100 MHz clock and an Avalon-MM register slave.
package flow_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int PC_W = 15;
    localparam int PM_AW = 12;
    localparam int PM_DW = 14;
    localparam int STACK_DEPTH = 16;
    localparam int SP_W = 5;
    localparam int PTR_W = 16;
    localparam int DM_AW = 12;
    localparam int CLS_W = 6;
    localparam int NUM_INSTR = 49;
    localparam int PM_SEL_BIT = 15;

    localparam logic [PC_W-1:0] RESET_VECTOR = 15'h0000;
    localparam logic [PC_W-1:0] INT_VECTOR = 15'h0004;
    localparam logic [SP_W-1:0] SP_FULL = 5'h10;

    // Linear view of general purpose RAM: 80 bytes per bank, 32 banks.
    localparam logic [PTR_W-1:0] LIN_BASE = 16'h2000;
    localparam logic [PTR_W-1:0] LIN_SPAN = 16'h0A00;
    localparam logic [PTR_W-1:0] LIN_BANK_BYTES = 16'h0050;
    localparam logic [6:0] GPR_OFFSET = 7'h20;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_POWER_CONTROL = 8'h04;
    localparam logic [7:0] REG_EVT_STATUS = 8'h08;
    localparam logic [7:0] REG_EVT_CLEAR = 8'h0C;
    localparam logic [7:0] REG_EVT_ENABLE = 8'h10;
    localparam logic [7:0] REG_POINTER0 = 8'h14;
    localparam logic [7:0] REG_POINTER1 = 8'h18;
    localparam logic [7:0] REG_FLOW = 8'h1C;

    localparam int CTRL_STK_RST_BIT = 0;
    localparam int OVF_BIT = 0;
    localparam int UNF_BIT = 1;
    localparam int EVT_ILLEGAL_BIT = 2;
    localparam int EVT_INT_BIT = 3;
    localparam int EVT_W = 4;
    localparam int FLOW_SP_LSB = 16;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_STEP = 4'h0, OP_GOTO = 4'h1, OP_CALL = 4'h2, OP_RETURN = 4'h3,
        OP_INT_ENTRY = 4'h4, OP_RETFIE = 4'h5, OP_PTR_LOAD = 4'h6,
        OP_IND_READ = 4'h7, OP_IND_WRITE = 4'h8
    } op_t;

    typedef enum logic [0:0] {MODE_RUN = 1'b0, MODE_PM_WAIT = 1'b1} mode_t;

    typedef struct packed {
        logic [7:0] w;
        logic [7:0] status;
        logic [7:0] bsr;
        logic [7:0] pclath;
    } ctx_t;

    typedef struct packed {
        op_t op;
        logic [CLS_W-1:0] insn_class;
        logic [PC_W-1:0] target;
        logic [PTR_W-1:0] data;
        logic sel;
    } cmd_t;

endpackage : flow_pkg

// [testbench.sv]
// Self-checking bench for the program-flow core and its memory model.
// Assumes nothing of bus latency; the watchdog ends any wait that never finishes.
`timescale 1ns/10ps
module testbench;
    logic clk, reset, avs_read, avs_write, avs_waitrequest, irq, cmd_valid, cmd_ready, seen;
    logic ctx_restore_valid, dm_we, ind_rvalid, soft_reset;
    logic [7:0] avs_address, dm_rdata, dm_wdata, ind_rdata;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [11:0] pm_addr, dm_addr;
    logic [13:0] pm_rdata;
    logic [14:0] pc;
    flow_pkg::cmd_t cmd;
    flow_pkg::ctx_t ctx_in, ctx_restore;
    int num_errors, checks_done, k;
    typedef struct {flow_pkg::op_t op; logic [5:0] c; logic [14:0] t; logic [14:0] e;} row_t;
    row_t rows[10] = '{'{flow_pkg::OP_STEP, 6'h00, 15'h0000, 15'h0001},
        '{flow_pkg::OP_GOTO, 6'h00, 15'h0FFE, 15'h0FFE}, '{flow_pkg::OP_STEP, 6'h30, 15'h0, 15'h0FFF},
        '{flow_pkg::OP_STEP, 6'h00, 15'h0, 15'h1000}, '{flow_pkg::OP_GOTO, 6'h00, 15'h7FFF, 15'h7FFF},
        '{flow_pkg::OP_STEP, 6'h00, 15'h0, 15'h0000}, '{flow_pkg::OP_CALL, 6'h00, 15'h0123, 15'h0123},
        '{flow_pkg::OP_RETURN, 6'h00, 15'h0, 15'h0001}, '{flow_pkg::OP_INT_ENTRY, 6'h00, 15'h0, 15'h0004},
        '{flow_pkg::OP_RETFIE, 6'h00, 15'h0, 15'h0001}};

    cpu_program_flow_core i_cpu_program_flow_core (.clk(clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .ctx_in(ctx_in), .ctx_restore(ctx_restore),
        .ctx_restore_valid(ctx_restore_valid), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .dm_addr(dm_addr), .dm_we(dm_we), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
        .ind_rdata(ind_rdata), .ind_rvalid(ind_rvalid), .pc(pc), .soft_reset(soft_reset));
    flow_mem_model i_flow_mem_model (.clk(clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .dm_addr(dm_addr), .dm_we(dm_we), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string msg);
        bus(1'b0, a, 32'h0);
        chk(q, e, msg);
    endtask : rdchk

    task automatic send(input flow_pkg::op_t op, input logic [14:0] t, input logic [15:0] d,
                        input logic s, input logic [5:0] c);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, insn_class: c, target: t, data: d, sel: s};
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask : send

    task automatic rdw(input logic [7:0] e);
        seen = 1'b0;
        for (int n = 0; n < 4 && !seen; n++) begin
            @(posedge clk);
            seen = (ind_rvalid === 1'b1);
        end
        chk(seen, 1'b1, "read valid");
        chk(ind_rdata, e, "read byte");
    endtask : rdw

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // A hang is cut short well after the expected few hundred cycles.
    initial begin
        #100000;
        num_errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {reset, avs_read, avs_write, cmd_valid} = 4'hF;
        {avs_read, avs_write, cmd_valid} = 3'h0;
        {avs_address, avs_writedata, cmd} = '0;
        ctx_in = 32'h3C5AA5C3;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(pc, 15'h0000, "reset pc");
        rdchk(flow_pkg::REG_POWER_CONTROL, 32'h0, "reset flags");
        rdchk(8'hFC, 32'h0, "unmapped read");
        bus(1'b1, flow_pkg::REG_EVT_ENABLE, 32'h8);
        $display("reset test done");
        for (k = 0; k < 10; k++) begin
            send(rows[k].op, rows[k].t, 16'h0, 1'b0, rows[k].c);
            if (k == 8) ctx_in <= 32'h0;
            #1;
            chk(pc, rows[k].e, "program counter");
            chk(pm_addr, rows[k].e[11:0], "program address");
        end
        chk(ctx_restore, 32'h3C5AA5C3, "restored context");
        chk(irq, 1'b1, "interrupt raised");
        bus(1'b1, flow_pkg::REG_EVT_CLEAR, 32'h8);
        #1;
        chk(irq, 1'b0, "interrupt cleared");
        $display("flow table done");
        send(flow_pkg::OP_GOTO, 15'h0100, 16'h0, 1'b0, 6'h00);
        for (k = 0; k < 17; k++) send(flow_pkg::OP_CALL, 15'h0200 + k, 16'h0, 1'b0, 6'h00);
        #1;
        chk(pc, 15'h0210, "overflow still jumps");
        rdchk(flow_pkg::REG_POWER_CONTROL, 32'h1, "overflow flag");
        rdchk(flow_pkg::REG_FLOW, 32'h00100210, "full stack depth");
        chk(irq, 1'b0, "masked event");
        bus(1'b1, flow_pkg::REG_EVT_ENABLE, 32'h1);
        #1;
        chk(irq, 1'b1, "unmasked event");
        rdchk(flow_pkg::REG_EVT_ENABLE, 32'h1, "enable readback");
        for (k = 15; k >= 0; k--) begin
            send(flow_pkg::OP_RETURN, 15'h0, 16'h0, 1'b0, 6'h00);
            #1;
            chk(pc, (k == 0) ? 32'h0101 : 32'h0200 + k, "return address");
        end
        send(flow_pkg::OP_RETURN, 15'h0, 16'h0, 1'b0, 6'h00);
        #1;
        chk(pc, 15'h0000, "underflow pc");
        rdchk(flow_pkg::REG_POWER_CONTROL, 32'h3, "underflow flag");
        bus(1'b1, flow_pkg::REG_POWER_CONTROL, 32'h0);
        rdchk(flow_pkg::REG_POWER_CONTROL, 32'h0, "flags cleared");
        bus(1'b1, flow_pkg::REG_EVT_CLEAR, 32'hF);
        bus(1'b1, flow_pkg::REG_CTRL, 32'h1);
        rdchk(flow_pkg::REG_CTRL, 32'h1, "stack reset armed");
        send(flow_pkg::OP_RETURN, 15'h0, 16'h0, 1'b0, 6'h00);
        seen = 1'b0;
        for (k = 0; k < 4 && !seen; k++) begin
            @(posedge clk);
            seen = (soft_reset === 1'b1);
        end
        chk(seen, 1'b1, "software reset pulse");
        chk(pc, 15'h0000, "software reset pc");
        send(flow_pkg::OP_STEP, 15'h0, 16'h0, 1'b0, 6'h31);
        bus(1'b1, flow_pkg::REG_EVT_STATUS, 32'h0);
        rdchk(flow_pkg::REG_EVT_STATUS, 32'h6, "illegal class event");
        rdchk(flow_pkg::REG_EVT_CLEAR, 32'h0, "clear reads zero");
        $display("stack test done");
        send(flow_pkg::OP_PTR_LOAD, 15'h0, 16'h8123, 1'b0, 6'h00);
        send(flow_pkg::OP_IND_READ, 15'h0, 16'h0, 1'b0, 6'h00);
        rdw(8'h7F);
        send(flow_pkg::OP_PTR_LOAD, 15'h0, 16'h2055, 1'b1, 6'h00);
        send(flow_pkg::OP_IND_WRITE, 15'h0, 16'h005A, 1'b1, 6'h00);
        chk(dm_addr, 12'h0A5, "linear address");
        send(flow_pkg::OP_IND_READ, 15'h0, 16'h0, 1'b1, 6'h00);
        rdw(8'h5A);
        send(flow_pkg::OP_PTR_LOAD, 15'h0, 16'h8010, 1'b1, 6'h00);
        send(flow_pkg::OP_IND_WRITE, 15'h0, 16'h00EE, 1'b1, 6'h00);
        chk(dm_we, 1'b0, "program write dropped");
        rdchk(flow_pkg::REG_POINTER1, 32'h8010, "pointer readback");
        $display("indirect test done");
        test_done();
    end
endmodule : testbench
